// ===== common/emp_pkg.sv
// Package of constants and types for the energy mode power manager
package emp_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] EMP_CTRL_OFS     = 8'h00;  // Scaling levels, retention, mode request
  localparam logic [7:0] EMP_PERIPH_OFS   = 8'h04;  // Peripheral in-use bits
  localparam logic [7:0] EMP_RAM_OFS      = 8'h08;  // RAM block power enables
  localparam logic [7:0] EMP_STATUS_OFS   = 8'h0C;  // Live state, read only
  localparam logic [7:0] EMP_IF_OFS       = 8'h10;  // Sticky flags, write one to clear
  localparam logic [7:0] EMP_IEN_OFS      = 8'h14;  // Interrupt mask
  localparam logic [7:0] EMP_RESET_OFS    = 8'h18;  // Software reset, last cause
  localparam logic [7:0] EMP_BYPASS_OFS   = 8'h1C;  // Buck bypass request

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ACT_LVL_LSB  = 0;   // Active/sleep scaling level, 2 bits
  localparam int CTRL_DS_LVL_LSB   = 2;   // Deep-sleep/stop scaling level, 2 bits
  localparam int CTRL_RET_DIS_BIT  = 4;   // Disable retention of active peripherals
  localparam int CTRL_MODE_LSB     = 8;   // Requested energy mode, 3 bits
  localparam int CTRL_FAST_CLK_BIT = 12;  // Software declares clock above 40 MHz

  // Peripheral in-use bits: domain b uses bits 6..0, domain c bit 8
  localparam int PERIPH_B_W        = 7;
  localparam int PERIPH_C_BIT      = 8;

  // Status register fields
  localparam int ST_MODE_LSB       = 0;   // Current mode, 3 bits
  localparam int ST_LVL_LSB        = 4;   // Applied level, 2 bits
  localparam int ST_SETTLED_BIT    = 6;
  localparam int ST_DOM_B_BIT      = 7;
  localparam int ST_DOM_C_BIT      = 8;
  localparam int ST_RET_BIT        = 9;
  localparam int ST_SUPPLY_LOW_BIT = 10;
  localparam int ST_BYPASS_BIT     = 11;
  localparam int ST_RAMP_BIT       = 12;

  // Interrupt flags
  localparam int IF_W              = 4;
  localparam int IF_SUPPLY_LOW     = 0;
  localparam int IF_MODE_DONE      = 1;
  localparam int IF_RAMP_DONE      = 2;
  localparam int IF_CLK_VIOL       = 3;

  // Reset register fields
  localparam int RST_SW_BIT        = 0;
  localparam logic [31:0] RST_KEY  = 32'h0000_A5A5;  // Software reset key in bits 31:16
  localparam int RST_CAUSE_LSB     = 8;   // Five cause bits

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;  // Full-speed level for active
  localparam logic [31:0] PERIPH_RESET = 32'h0000_01FF;  // All peripherals in use
  localparam logic [31:0] RAM_RESET    = 32'h0000_FFFF;  // All RAM powered

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int SETTLE_NS        = 2000;  // Regulator settle time
  localparam int SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_STEP_NS     = 500;   // Dwell per soft-switch step
  localparam int RAMP_STEP_CYC    = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int RAMP_STEPS       = 8;
  localparam int RST_PULSE_CYC    = 16;    // System reset pulse length

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EMP_LOWEST       = 2'd0,
    EMP_INTERMEDIATE = 2'd1,
    EMP_FULL_SPEED   = 2'd2
  } emp_level_t;

  typedef enum logic [2:0] {
    EMP_ACTIVE     = 3'd0,
    EMP_SLEEP      = 3'd1,
    EMP_DEEP_SLEEP = 3'd2,
    EMP_STOP       = 3'd3,
    EMP_SHUTOFF    = 3'd4
  } emp_mode_t;

  // Gray-coded sequencer along active -> enter -> low -> exit -> settle
  typedef enum logic [2:0] {
    SQ_RUN    = 3'b000,
    SQ_ENTER  = 3'b001,
    SQ_LOW    = 3'b011,
    SQ_EXIT   = 3'b010,
    SQ_SETTLE = 3'b110
  } emp_seq_t;

endpackage : emp_pkg

// ===== design/emp_ramp.sv
// Soft-switching ramp generator for boot and buck bypass entry
`timescale 1ns/100ps
module emp_ramp
  import emp_pkg::*;
#(
  parameter int STEP_CYC = RAMP_STEP_CYC,
  parameter int STEPS    = RAMP_STEPS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   start,
  output logic                        busy,
  output logic [$clog2(STEPS+1)-1:0]  level,
  output logic                        done
);

  localparam int SW = $clog2(STEPS + 1);
  localparam int CW = $clog2(STEP_CYC + 1);

  logic [CW-1:0] cnt_reg, cnt_next;     // Dwell counter per step
  logic [SW-1:0] lvl_reg, lvl_next;     // Current step of the ramp
  logic          busy_reg, busy_next;
  logic          done_reg, done_next;

  // ---------------------------------------------------------------
  // Step logic
  // ---------------------------------------------------------------
  // Slow steps limit slew rate and inrush current
  always_comb begin
    cnt_next  = cnt_reg;
    lvl_next  = lvl_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start && !busy_reg) begin
      // Restart from the bottom
      busy_next = 1'b1;
      lvl_next  = '0;
      cnt_next  = '0;
    end else if (busy_reg) begin
      if (cnt_reg == CW'(STEP_CYC - 1)) begin
        cnt_next = '0;
        if (lvl_reg == SW'(STEPS)) begin
          busy_next = 1'b0;
          done_next = 1'b1;
        end else begin
          lvl_next = lvl_reg + SW'(1);
        end
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      lvl_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lvl_reg  <= lvl_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy  = busy_reg;
  assign level = lvl_reg;
  assign done  = done_reg;

endmodule : emp_ramp

// ===== design/emp_power_manager.sv
// Energy mode power manager: scaling, domains, retention, RAM, supply, resets
// ---------------------------------------------------------------
// Summary of operation
// R1 - Separate levels for active and deep-sleep groups
// R2 - Reset selects full-speed level for active
// R3 - Intermediate level permits clocks up to 40 MHz
// R4 - Lowest level allowed only for deep-sleep group
// R5 - Mode change applies destination level automatically
// R6 - Always-on plus two switchable peripheral domains
// R7 - Unused switchable domain unpowered in deep sleep
// R8 - Fixed always-on peripheral set stays powered
// R9 - Domain b seven peripherals, domain c oscillator
// R10 - Software may drop active peripheral retention
// R11 - Software removes power from unused RAM
// R12 - Low supply raises maskable interrupt for bypass
// R13 - Soft ramp at boot and bypass entry
// R14 - Five reset sources reset the system
// R15 - Hold core until active level settled
// ---------------------------------------------------------------
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module emp_power_manager
  import emp_pkg::*;
#(
  parameter int RAM_BLOCKS = 16
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  supply_low_pin,
  input  wire logic                  reset_pin_n,
  input  wire logic                  monitor_fault,
  input  wire logic                  core_lockup,
  input  wire logic                  watchdog_expired,
  input  wire logic                  wake_event,
  output logic [1:0]                 regulator_level,
  output logic                       core_hold,
  output logic                       always_on_power,
  output logic                       switchable_domain_b,
  output logic                       switchable_domain_c,
  output logic                       retention_en,
  output logic [RAM_BLOCKS-1:0]      ram_power,
  output logic                       buck_bypass,
  output logic [3:0]                 ramp_level,
  output logic                       sys_reset,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // Synchronisers for pin inputs
  // ---------------------------------------------------------------
  logic [5:0] sync1_reg, sync2_reg;  // Two-stage chain per pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 6'b00_0010;
      sync2_reg <= 6'b00_0010;
    end else begin
      sync1_reg <= {wake_event, watchdog_expired, core_lockup, monitor_fault, reset_pin_n, supply_low_pin};
      sync2_reg <= sync1_reg;
    end
  end
  logic s_supply_low, s_pin_rst, s_monitor, s_lockup, s_wdog, s_wake;
  assign {s_wake, s_wdog, s_lockup, s_monitor, s_pin_rst, s_supply_low} =
         {sync2_reg[5:2], ~sync2_reg[1], sync2_reg[0]};

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [31:0]       ctrl_reg, ctrl_next;        // Levels, retention, mode
  logic [8:0]        periph_reg, periph_next;    // Peripheral in-use bits
  logic [RAM_BLOCKS-1:0] ram_reg, ram_next;      // RAM block enables
  logic [IF_W-1:0]   if_reg, if_next;            // Sticky flags
  logic [IF_W-1:0]   ien_reg, ien_next;          // Mask
  logic              byp_req_reg, byp_req_next;  // Bypass request
  logic              sw_rst_req;                 // One-cycle software reset
  logic [31:0]       prdata_reg, prdata_next;
  logic              pready_reg, pready_next;
  logic              pslverr_reg, pslverr_next;
  logic [4:0]        cause_reg, cause_next;      // Last reset cause

  // Sequencer state
  emp_seq_t          seq_reg, seq_next;
  emp_mode_t         mode_reg, mode_next;
  logic [1:0]        lvl_reg, lvl_next;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_reg, settle_next;
  logic              hold_reg, hold_next;
  logic [3:0]        ev_set;                     // Flag set events this cycle

  // Ramp engine
  logic              ramp_start, ramp_busy, ramp_done;
  logic [$clog2(RAMP_STEPS+1)-1:0] ramp_lvl;
  logic              boot_reg;                   // Boot ramp launched
  logic              supply_low_d_reg;

  // Clamp a requested level to what a mode group allows
  function automatic logic [1:0] clamp_level(input logic [1:0] lvl, input logic deep);
    logic [1:0] r;
    r = lvl;
    if (lvl > 2'(EMP_FULL_SPEED))
      r = 2'(EMP_FULL_SPEED);
    if (!deep && lvl == 2'(EMP_LOWEST))  // Lowest is never used while active [R4]
      r = 2'(EMP_INTERMEDIATE);
    return r;
  endfunction : clamp_level

  logic [1:0] act_lvl, ds_lvl;
  assign act_lvl = clamp_level(ctrl_reg[CTRL_ACT_LVL_LSB +: 2], 1'b0);  // [R1]
  assign ds_lvl  = clamp_level(ctrl_reg[CTRL_DS_LVL_LSB +: 2], 1'b1);   // [R1]
  logic deep_mode;
  assign deep_mode = (mode_reg == EMP_DEEP_SLEEP) || (mode_reg == EMP_STOP);

  // ---------------------------------------------------------------
  // APB slave, answers with one wait state
  // ---------------------------------------------------------------
  logic acc;
  assign acc = psel && penable && !pready_reg;
  always_comb begin
    ctrl_next    = ctrl_reg;
    periph_next  = periph_reg;
    ram_next     = ram_reg;
    ien_next     = ien_reg;
    byp_req_next = byp_req_reg;
    sw_rst_req   = 1'b0;
    prdata_next  = prdata_reg;
    pready_next  = acc;
    pslverr_next = 1'b0;
    // Set wins over write-one-to-clear
    if_next      = if_reg;
    if (acc && pwrite && paddr == EMP_IF_OFS)
      if_next = if_reg & ~pwdata[IF_W-1:0];
    if_next = if_next | ev_set;
    if (acc) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        EMP_CTRL_OFS: begin
          if (pwrite) ctrl_next = pwdata & 32'h0000_171F;
          prdata_next = ctrl_reg;
        end
        EMP_PERIPH_OFS: begin
          if (pwrite) periph_next = pwdata[8:0];
          prdata_next = {23'd0, periph_reg};
        end
        EMP_RAM_OFS: begin
          if (pwrite) ram_next = pwdata[RAM_BLOCKS-1:0];  // [R11]
          prdata_next = 32'(ram_reg);
        end
        EMP_STATUS_OFS: begin
          prdata_next[ST_MODE_LSB +: 3]   = mode_reg;
          prdata_next[ST_LVL_LSB +: 2]    = lvl_reg;
          prdata_next[ST_SETTLED_BIT]     = !hold_reg;
          prdata_next[ST_DOM_B_BIT]       = switchable_domain_b;
          prdata_next[ST_DOM_C_BIT]       = switchable_domain_c;
          prdata_next[ST_RET_BIT]         = retention_en;
          prdata_next[ST_SUPPLY_LOW_BIT]  = s_supply_low;
          prdata_next[ST_BYPASS_BIT]      = byp_req_reg;
          prdata_next[ST_RAMP_BIT]        = ramp_busy;
        end
        EMP_IF_OFS:  prdata_next = 32'(if_reg);
        EMP_IEN_OFS: begin
          if (pwrite) ien_next = pwdata[IF_W-1:0];
          prdata_next = 32'(ien_reg);
        end
        EMP_RESET_OFS: begin
          if (pwrite && pwdata[31:16] == RST_KEY[15:0] && pwdata[RST_SW_BIT])
            sw_rst_req = 1'b1;                                    // [R14]
          prdata_next = {19'd0, cause_reg, 8'd0};
        end
        EMP_BYPASS_OFS: begin
          if (pwrite) byp_req_next = pwdata[0];                   // [R12]
          prdata_next = {31'd0, byp_req_reg};
        end
        default: pslverr_next = 1'b1;  // Unmapped address
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Energy mode sequencer
  // ---------------------------------------------------------------
  // Level always follows the destination group without software [R5]
  always_comb begin
    seq_next    = seq_reg;
    mode_next   = mode_reg;
    lvl_next    = lvl_reg;
    settle_next = settle_reg;
    hold_next   = hold_reg;
    ev_set      = '0;
    ev_set[IF_SUPPLY_LOW] = s_supply_low && !supply_low_d_reg;   // [R12]
    ev_set[IF_RAMP_DONE]  = ramp_done;
    // Fast clock at intermediate level is flagged [R3]
    ev_set[IF_CLK_VIOL]   = ctrl_reg[CTRL_FAST_CLK_BIT] && !deep_mode &&
                            lvl_reg == 2'(EMP_INTERMEDIATE);
    case (seq_reg)
      SQ_RUN: begin
        lvl_next = act_lvl;                                      // [R5]
        if (ctrl_reg[CTRL_MODE_LSB +: 3] >= 3'(EMP_DEEP_SLEEP) &&
            ctrl_reg[CTRL_MODE_LSB +: 3] <= 3'(EMP_STOP)) begin
          seq_next = SQ_ENTER;
        end else begin
          mode_next = (ctrl_reg[CTRL_MODE_LSB +: 3] == 3'(EMP_SLEEP)) ? EMP_SLEEP : EMP_ACTIVE;
        end
      end
      SQ_ENTER: begin
        mode_next = emp_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
        hold_next = 1'b1;
        seq_next  = SQ_LOW;
        ev_set[IF_MODE_DONE] = 1'b1;
      end
      SQ_LOW: begin
        lvl_next = ds_lvl;                                       // [R4] [R5]
        if (s_wake) seq_next = SQ_EXIT;
      end
      SQ_EXIT: begin
        mode_next   = EMP_ACTIVE;
        lvl_next    = act_lvl;                                   // [R5]
        settle_next = '0;
        seq_next    = SQ_SETTLE;
      end
      SQ_SETTLE: begin
        // Core stays held until the regulator reaches its level [R15]
        if (settle_reg == $bits(settle_reg)'(SETTLE_CYC - 1)) begin
          hold_next = 1'b0;
          seq_next  = SQ_RUN;
          ev_set[IF_MODE_DONE] = 1'b1;
        end else begin
          settle_next = settle_reg + 1'b1;
        end
      end
      default: seq_next = SQ_RUN;
    endcase
  end

  // Mode request bits clear on wake so the core does not re-enter at once
  logic clr_req;
  assign clr_req = (seq_reg == SQ_EXIT);

  // ---------------------------------------------------------------
  // Resets, ramp start, registers
  // ---------------------------------------------------------------
  logic [4:0] rst_src;
  assign rst_src = {sw_rst_req, s_wdog, s_lockup, s_pin_rst, s_monitor};  // [R14]
  logic [4:0] rst_cnt_reg;
  assign cause_next = (rst_src != 5'd0) ? rst_src : cause_reg;
  assign ramp_start = !boot_reg || (byp_req_next && !byp_req_reg);        // [R13]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg    <= CTRL_RESET;                                          // [R2]
      periph_reg  <= PERIPH_RESET[8:0];
      ram_reg     <= RAM_RESET[RAM_BLOCKS-1:0];
      if_reg      <= '0;
      ien_reg     <= '0;
      byp_req_reg <= 1'b0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      cause_reg   <= '0;
      seq_reg     <= SQ_RUN;
      mode_reg    <= EMP_ACTIVE;
      lvl_reg     <= 2'(EMP_FULL_SPEED);                                  // [R2]
      settle_reg  <= '0;
      hold_reg    <= 1'b0;
      boot_reg    <= 1'b0;
      supply_low_d_reg <= 1'b0;
      rst_cnt_reg <= '0;
    end else begin
      ctrl_reg    <= clr_req ? (ctrl_next & ~32'h0000_0700) : ctrl_next;
      periph_reg  <= periph_next;
      ram_reg     <= ram_next;
      if_reg      <= if_next;
      ien_reg     <= ien_next;
      byp_req_reg <= byp_req_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      cause_reg   <= cause_next;
      seq_reg     <= seq_next;
      mode_reg    <= mode_next;
      lvl_reg     <= lvl_next;
      settle_reg  <= settle_next;
      hold_reg    <= hold_next;
      boot_reg    <= 1'b1;
      supply_low_d_reg <= s_supply_low;
      // Hold system reset while any source is active and for RST_PULSE_CYC cycles after it drops
      rst_cnt_reg <= (rst_src != 5'd0) ? 5'(RST_PULSE_CYC) :
                     (rst_cnt_reg != 5'd0) ? rst_cnt_reg - 5'd1 : 5'd0;
    end
  end

  emp_ramp u_ramp (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (ramp_start),
    .busy    (ramp_busy),
    .level   (ramp_lvl),
    .done    (ramp_done)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [RAM_BLOCKS-1:0] ram_o_reg;
  logic [1:0] lvl_o_reg;
  logic hold_o_reg, dom_b_reg, dom_c_reg, ret_reg, byp_o_reg, irq_reg, srst_reg;
  logic [3:0] rl_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvl_o_reg <= 2'(EMP_FULL_SPEED);
      hold_o_reg <= 1'b1;
      dom_b_reg <= 1'b1;
      dom_c_reg <= 1'b1;
      ret_reg   <= 1'b1;
      ram_o_reg <= RAM_RESET[RAM_BLOCKS-1:0];
      byp_o_reg <= 1'b0;
      rl_reg    <= '0;
      irq_reg   <= 1'b0;
      srst_reg  <= 1'b0;
    end else begin
      lvl_o_reg  <= lvl_reg;
      // The boot ramp starts a cycle after release; cover that gap so the core never sees a false release
      hold_o_reg <= hold_reg || ramp_busy || !boot_reg;                   // [R15]
      // Domains drop only in deep modes when all members unused [R6] [R7] [R9]
      dom_b_reg  <= !deep_mode || (periph_reg[PERIPH_B_W-1:0] != '0);
      dom_c_reg  <= !deep_mode || periph_reg[PERIPH_C_BIT];
      ret_reg    <= !(deep_mode && ctrl_reg[CTRL_RET_DIS_BIT]);           // [R10]
      ram_o_reg  <= ram_reg;                                              // [R11]
      byp_o_reg  <= byp_req_reg && !ramp_busy;                            // [R13]
      rl_reg     <= 4'(ramp_lvl);
      irq_reg    <= |(if_reg & ien_reg);                                  // [R12]
      srst_reg   <= (rst_cnt_reg != 5'd0);                                // [R14]
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign regulator_level     = lvl_o_reg;
  assign core_hold           = hold_o_reg;
  assign always_on_power     = 1'b1;  // Calendar, oscillators, backup, rf sensor [R8]
  assign switchable_domain_b = dom_b_reg;
  assign switchable_domain_c = dom_c_reg;
  assign retention_en        = ret_reg;
  assign ram_power           = ram_o_reg;
  assign buck_bypass         = byp_o_reg;
  assign ramp_level          = rl_reg;
  assign sys_reset           = srst_reg;
  assign irq                 = irq_reg;

endmodule : emp_power_manager

// ===== verification/emp_power_manager_properties.sv
// Port-level assertions for the energy mode power manager
`timescale 1ns/100ps
module emp_power_manager_properties
  import emp_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [1:0] regulator_level,
  input wire logic       core_hold,
  input wire logic       always_on_power,
  input wire logic       switchable_domain_b,
  input wire logic       switchable_domain_c,
  input wire logic       retention_en,
  input wire logic [3:0] ramp_level,
  input wire logic       sys_reset
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Held-cycle counter, saturating so a long hold never wraps
  // ---------------------------------------------------------------
  logic [15:0] hold_cnt_reg;
  logic [15:0] hold_cnt_next;
  always_comb begin
    hold_cnt_next = core_hold ? hold_cnt_reg + 16'h0001 : 16'h0000;
    if (core_hold && hold_cnt_reg == 16'hFFFF) hold_cnt_next = hold_cnt_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) hold_cnt_reg <= 16'h0000;
    else hold_cnt_reg <= hold_cnt_next;
  end
  property p_reset_level; $fell(rst) |-> regulator_level == 2'h2 && core_hold; endproperty
  a_reset_level: assert property (p_reset_level) else $error("bad level after reset");
  property p_always_on; always_on_power; endproperty
  a_always_on: assert property (p_always_on) else $error("always-on rail dropped");
  property p_level_legal; regulator_level != 2'h3; endproperty
  a_level_legal: assert property (p_level_legal) else $error("undefined level");
  property p_release_level; $fell(core_hold) |-> regulator_level != 2'h0; endproperty
  a_release_level: assert property (p_release_level) else $error("core run at lowest");
  property p_release_power;
    $fell(core_hold) |-> switchable_domain_b && switchable_domain_c && retention_en; endproperty
  a_release_power: assert property (p_release_power) else $error("domain off at wake");
  property p_settle; $fell(core_hold) |-> hold_cnt_reg >= 16'(SETTLE_CYC - 1); endproperty
  a_settle: assert property (p_settle) else $error("core freed before settle");
  property p_rst_pulse; $rose(sys_reset) |=> sys_reset[*8] ##[1:40] !sys_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length");
  property p_ramp_step;
    $changed(ramp_level) |-> ramp_level == $past(ramp_level) + 4'h1 || ramp_level == 4'h0; endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp skipped a step");
endmodule : emp_power_manager_properties
bind emp_power_manager emp_power_manager_properties u_props (.ref_clk(ref_clk), .rst(rst),
  .regulator_level(regulator_level), .core_hold(core_hold), .always_on_power(always_on_power),
  .switchable_domain_b(switchable_domain_b), .switchable_domain_c(switchable_domain_c),
  .retention_en(retention_en), .ramp_level(ramp_level), .sys_reset(sys_reset));

// ===== verification/energy_mode_power_manager_tb.sv
// Self-checking bench for the energy mode power manager
`timescale 1ns/100ps
module energy_mode_power_manager_tb import emp_pkg::*;;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, irq, sys_reset;
  logic        supply_low_pin, reset_pin_n, monitor_fault, core_lockup, watchdog_expired;
  logic        wake_event, core_hold, always_on_power, retention_en, buck_bypass;
  logic        switchable_domain_b, switchable_domain_c;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [1:0]  regulator_level, act, dl;
  logic [15:0] ram_power;
  logic [3:0]  ramp_level;
  int          n_fail = 0;
  int          n_compared = 0;
  emp_power_manager #(.RAM_BLOCKS(16)) dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .supply_low_pin, .reset_pin_n, .monitor_fault,
    .core_lockup, .watchdog_expired, .wake_event, .regulator_level, .core_hold, .always_on_power,
    .switchable_domain_b, .switchable_domain_c, .retention_en, .ram_power, .buck_bypass,
    .ramp_level, .sys_reset, .irq);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for a level; a hang ends the run as a mismatch
  task automatic wait_sig(ref logic s, input logic v);
    for (int k = 0; k < 3000 && s !== v; k++) @(posedge ref_clk);
    chk(s, v);
    if (s !== v) complete_run();
  endtask : wait_sig
  // One APB transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    wait_sig(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);  // Idle edge between transfers; registered outputs settle
  endtask : xfer
  task automatic src(input int s);
    monitor_fault <= (s == 1);
    reset_pin_n <= (s != 2);
    core_lockup <= (s == 3);
    watchdog_expired <= (s == 4);
  endtask : src
  initial begin
    {rst, supply_low_pin, reset_pin_n} = 3'b101;
    {psel, penable, pwrite, monitor_fault, core_lockup, watchdog_expired, wake_event} = '0;
    {paddr, pwdata} = '0;
    r = $urandom(19236);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(0, EMP_CTRL_OFS, 0);
    chk(rd, CTRL_RESET);
    xfer(0, EMP_PERIPH_OFS, 0);
    chk(rd, PERIPH_RESET);
    wait_sig(core_hold, 1'b0);
    xfer(0, EMP_IF_OFS, 0);
    chk(rd[IF_RAMP_DONE], 1);
    xfer(1, 8'h20, 32'hFFFF_FFFF);
    chk(err, 1);
    r = $urandom;
    xfer(1, EMP_RAM_OFS, {16'h0000, r[15:0]});
    chk(ram_power, r[15:0]);
    xfer(1, EMP_IF_OFS, 32'h0000_000F);
    xfer(1, EMP_IEN_OFS, 32'h0000_0002);
    // Deep-sleep and stop modes, with lowest level and empty domains forced first
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      act = r[21:20] % 3;
      dl = (i < 2) ? 2'h0 : r[3:2] % 3;
      if (i == 0) r[12:4] = 9'h000;
      xfer(1, EMP_PERIPH_OFS, {23'h0, r[12:4]});
      xfer(1, EMP_CTRL_OFS, {22'h0, 1'b1, i[0], 3'h0, r[16], dl, act});
      wait_sig(irq, 1'b1);
      xfer(1, EMP_IF_OFS, 32'h0000_0002);
      chk(regulator_level, dl);
      chk(switchable_domain_b, r[10:4] != 0);
      chk(switchable_domain_c, r[12]);
      chk(retention_en, !r[16]);
      wake_event <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wake_event <= 1'b0;
      wait_sig(irq, 1'b1);
      xfer(1, EMP_IF_OFS, 32'h0000_0002);
      chk({core_hold, regulator_level}, {1'b0, (act == 2'h0) ? 2'h1 : act});
    end
    xfer(1, EMP_IEN_OFS, 32'h0000_0001);
    supply_low_pin <= 1'b1;
    wait_sig(irq, 1'b1);
    xfer(1, EMP_IEN_OFS, 0);
    chk(irq, 0);
    xfer(1, EMP_IF_OFS, 32'h0000_0001);
    xfer(0, EMP_IF_OFS, 0);
    chk(rd[IF_SUPPLY_LOW], 0);
    xfer(1, EMP_CTRL_OFS, 32'h0000_1001);
    xfer(0, EMP_IF_OFS, 0);
    chk(rd[IF_CLK_VIOL], 1);
    xfer(1, EMP_BYPASS_OFS, 32'h0000_0001);
    chk(buck_bypass, 0);
    wait_sig(buck_bypass, 1'b1);
    for (int s = 0; s < 5; s++) begin
      if (s == 0) xfer(1, EMP_RESET_OFS, 32'hA5A5_0001);
      src(s);
      wait_sig(sys_reset, 1'b1);
      src(9);
      wait_sig(sys_reset, 1'b0);
    end
    xfer(0, EMP_RESET_OFS, 0);
    chk(rd[RST_CAUSE_LSB +: 5], 32'h0000_0008);
    complete_run();
  end
endmodule : energy_mode_power_manager_tb
